// ===== hw/tacl_config.sv
// configuration register, trip status and alert pin control
`timescale 1ns/1ps
module tacl_config
	import tacl_pkg::*;
#(
	parameter int TW = 13
) (
	input  wire logic          ref_clk,         // device clock, 40 MHz
	input  wire logic          reset_n,         // power-on reset, sync, low
	input  wire logic [7:0]    reg_addr,        // register pointer from bus engine
	input  wire logic          reg_wr,          // one-cycle write strobe
	input  wire logic [15:0]   reg_wdata,       // write data
	input  wire logic          reg_rd,          // one-cycle read strobe
	output logic      [15:0]   reg_rdata,       // read data, config only
	input  wire logic          temp_valid,      // one-cycle new conversion
	input  wire logic [TW-1:0] temp_value,      // signed temperature
	input  wire logic [TW-1:0] upper_limit,     // signed upper window limit
	input  wire logic [TW-1:0] lower_limit,     // signed lower window limit
	input  wire logic [TW-1:0] crit_limit,      // signed critical limit
	output logic               upper_limit_we,  // allowed write of upper limit
	output logic               lower_limit_we,  // allowed write of lower limit
	output logic               crit_limit_we,   // allowed write of critical limit
	output logic               sensor_off,      // powers down diode and converter
	output tacl_trip_type      trip_status,     // temperature bits 15:13
	output logic               alert_pin_o,     // alert pin level, always 0
	output logic               alert_pin_oe     // open-drain pull enable
);

	// ------------------------------------------------
	// functions
	// ------------------------------------------------
	function automatic logic [13:0] hys_amount(input logic [1:0] sel);
		case (sel)
			2'b00: hys_amount = TACL_HYS_0;
			2'b01: hys_amount = TACL_HYS_1P5;
			2'b10: hys_amount = TACL_HYS_3;
			default: hys_amount = TACL_HYS_6;
		endcase
	endfunction

	function automatic logic signed [13:0] widen(input logic [TW-1:0] v);
		widen = 14'(signed'(v));
	endfunction

	// ------------------------------------------------
	// configuration register
	// ------------------------------------------------
	tacl_cfg_type   cfg_q;
	tacl_trip_type  trip_q;
	tacl_trip_type  trip_d;
	tacl_alert_type alert_state_q;
	logic           alert_q;
	logic           cond_q;
	logic           cond_d;
	logic           any_lock;
	logic           cfg_wr;
	logic           clear_req;
	logic           alert_now;
	logic           pin_oe_q;
	logic [15:0]    rdata_q;
	logic [13:0]    hys;
	logic signed [13:0] t;
	logic signed [13:0] up;
	logic signed [13:0] lo;
	logic signed [13:0] cr;

	assign any_lock  = cfg_q.crit_lock | cfg_q.win_lock;
	assign cfg_wr    = reg_wr & (reg_addr == TACL_CFG_ADDR);
	assign clear_req = cfg_wr & reg_wdata[TACL_CLR_BIT] & cfg_q.int_mode;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfg_q <= tacl_cfg_type'(9'h000);
		end else if (cfg_wr) begin
			// locks only ever set; cleared by reset alone
			cfg_q.crit_lock <= cfg_q.crit_lock | reg_wdata[TACL_CLOCK_BIT];
			cfg_q.win_lock  <= cfg_q.win_lock | reg_wdata[TACL_WLOCK_BIT];
			if (!reg_wdata[TACL_SHDN_BIT]) begin
				cfg_q.shutdown <= 1'b0;
			end else if (!any_lock) begin
				cfg_q.shutdown <= 1'b1;
			end
			// locked fields keep their value, other fields still update
			if (!any_lock) begin
				cfg_q.hys_sel   <= reg_wdata[TACL_HYS_HI:TACL_HYS_LO];
				cfg_q.out_en    <= reg_wdata[TACL_EN_BIT];
				cfg_q.crit_only <= reg_wdata[TACL_CONLY_BIT];
				cfg_q.polarity  <= reg_wdata[TACL_POL_BIT];
				cfg_q.int_mode  <= reg_wdata[TACL_MODE_BIT];
			end
		end
	end

	assign sensor_off = cfg_q.shutdown;

	// ------------------------------------------------
	// limit register write protection
	// ------------------------------------------------
	always_comb begin
		crit_limit_we  = reg_wr & (reg_addr == TACL_CRIT_ADDR) & ~cfg_q.crit_lock;
		upper_limit_we = reg_wr & (reg_addr == TACL_UPPER_ADDR) & ~cfg_q.win_lock;
		lower_limit_we = reg_wr & (reg_addr == TACL_LOWER_ADDR) & ~cfg_q.win_lock;
	end

	// ------------------------------------------------
	// trip status with hysteresis
	// ------------------------------------------------
	always_comb begin
		hys    = hys_amount(cfg_q.hys_sel);
		t      = widen(temp_value);
		up     = widen(upper_limit);
		lo     = widen(lower_limit);
		cr     = widen(crit_limit);
		trip_d = trip_q;
		if (!trip_q.below && (t <= lo - signed'(hys))) begin
			trip_d.below = 1'b1;
		end else if (trip_q.below && (t >= lo)) begin
			trip_d.below = 1'b0;
		end
		if (!trip_q.above && (t > up)) begin
			trip_d.above = 1'b1;
		end else if (trip_q.above && (t <= up - signed'(hys))) begin
			trip_d.above = 1'b0;
		end
		if (!trip_q.crit && (t > cr)) begin
			trip_d.crit = 1'b1;
		end else if (trip_q.crit && (t <= cr - signed'(hys))) begin
			trip_d.crit = 1'b0;
		end
	end

	// trip bits ignore pin, mode and clear; frozen while shut down
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			trip_q <= tacl_trip_type'(3'h0);
		end else if (temp_valid && !cfg_q.shutdown) begin
			trip_q <= trip_d;
		end
	end

	assign trip_status = trip_q;

	// ------------------------------------------------
	// alert condition and mode
	// ------------------------------------------------
	// same hysteresis-qualified bits drive the pin
	always_comb begin
		cond_d = trip_q.crit | (~cfg_q.crit_only & (trip_q.above | trip_q.below));
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cond_q <= 1'b0;
		end else if (!cfg_q.shutdown) begin
			cond_q <= cond_d;
		end
	end

	// interrupt latch: a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			alert_state_q <= TACL_IDLE;
		end else begin
			case (alert_state_q)
				TACL_IDLE: begin
					if (cfg_q.int_mode && !cfg_q.shutdown && cond_d && !cond_q) begin
						alert_state_q <= TACL_LATCHED;
					end
				end
				TACL_LATCHED: begin
					if (!cfg_q.int_mode) begin
						alert_state_q <= TACL_IDLE;
					end else if (clear_req && !(cond_d && !cond_q && !cfg_q.shutdown)) begin
						alert_state_q <= TACL_IDLE;
					end
				end
				default: alert_state_q <= TACL_IDLE;
			endcase
		end
	end

	assign alert_now = cfg_q.int_mode ? (alert_state_q == TACL_LATCHED) : cond_q;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= alert_now & cfg_q.out_en;
		end
	end

	// ------------------------------------------------
	// alert pin, open drain
	// ------------------------------------------------
	// pulled low when asserted active low, or when idle active high
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_oe_q <= 1'b0;
		end else begin
			pin_oe_q <= cfg_q.out_en & ((alert_now & cfg_q.out_en) ^ cfg_q.polarity);
		end
	end

	assign alert_pin_o  = 1'b0;
	assign alert_pin_oe = pin_oe_q;

	// ------------------------------------------------
	// read back
	// ------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdata_q <= TACL_CFG_RESET;
		end else if (reg_rd) begin
			rdata_q <= TACL_CFG_RESET;
			if (reg_addr == TACL_CFG_ADDR) begin
				rdata_q[TACL_HYS_HI:TACL_HYS_LO] <= cfg_q.hys_sel;
				rdata_q[TACL_SHDN_BIT]           <= cfg_q.shutdown;
				rdata_q[TACL_CLOCK_BIT]          <= cfg_q.crit_lock;
				rdata_q[TACL_WLOCK_BIT]          <= cfg_q.win_lock;
				rdata_q[TACL_CLR_BIT]            <= 1'b0;
				rdata_q[TACL_STAT_BIT]           <= alert_q;
				rdata_q[TACL_EN_BIT]             <= cfg_q.out_en;
				rdata_q[TACL_CONLY_BIT]          <= cfg_q.crit_only;
				rdata_q[TACL_POL_BIT]            <= cfg_q.polarity;
				rdata_q[TACL_MODE_BIT]           <= cfg_q.int_mode;
			end
		end
	end

	assign reg_rdata = rdata_q;

endmodule

// ===== pkg/tacl_pkg.sv
// constants and types for the thermal alert configuration logic
// Overview of operation
// - bit 8 shuts sensor and converter down
// - no new alert events while shut down
// - shutdown set blocked by locks, clear always
// - bit 7 locks critical limit writes
// - lock bits sticky until power-on reset
// - bit 6 locks both window limit writes
// - clear_alert releases latched alert, interrupt mode
// - clear_alert always reads back zero
// - bit 4 reads alert pin assertion
// - writes to alert_status are ignored
// - bit 3 output enable, lock protected
// - bit 2 critical only, lock protected
// - bit 1 polarity, lock protected
// - bit 0 interrupt mode, lock protected
// - hysteresis applies to pin and trip bits
// - trip bits set and clear with hysteresis
// - trip bits show the alert cause
// - bits 10:9 select hysteresis, lock protected
// - trip bits follow temperature, frozen while shut down
package tacl_pkg;
	localparam logic [7:0]  TACL_CFG_ADDR   = 8'h01;
	localparam logic [7:0]  TACL_UPPER_ADDR = 8'h02;
	localparam logic [7:0]  TACL_LOWER_ADDR = 8'h03;
	localparam logic [7:0]  TACL_CRIT_ADDR  = 8'h04;
	localparam int          TACL_HYS_HI     = 10;
	localparam int          TACL_HYS_LO     = 9;
	localparam int          TACL_SHDN_BIT   = 8;
	localparam int          TACL_CLOCK_BIT  = 7;
	localparam int          TACL_WLOCK_BIT  = 6;
	localparam int          TACL_CLR_BIT    = 5;
	localparam int          TACL_STAT_BIT   = 4;
	localparam int          TACL_EN_BIT     = 3;
	localparam int          TACL_CONLY_BIT  = 2;
	localparam int          TACL_POL_BIT    = 1;
	localparam int          TACL_MODE_BIT   = 0;
	localparam logic [15:0] TACL_CFG_RESET  = 16'h0000;
	// hysteresis in temperature lsbs of 0.0625 degC
	localparam logic [13:0] TACL_HYS_0      = 14'h0000;
	localparam logic [13:0] TACL_HYS_1P5    = 14'h0018;
	localparam logic [13:0] TACL_HYS_3      = 14'h0030;
	localparam logic [13:0] TACL_HYS_6      = 14'h0060;

	typedef struct packed {
		logic [1:0] hys_sel;
		logic       shutdown;
		logic       crit_lock;
		logic       win_lock;
		logic       out_en;
		logic       crit_only;
		logic       polarity;
		logic       int_mode;
	} tacl_cfg_type;

	// trip status, bit order 15:13 of the temperature register
	typedef struct packed {
		logic crit;
		logic above;
		logic below;
	} tacl_trip_type;

	typedef enum logic [0:0] {
		TACL_IDLE    = 1'b0,
		TACL_LATCHED = 1'b1
	} tacl_alert_type;
endpackage

// ===== tb/tacl_config_sva.sv
// assertions on the configuration and alert control ports
`timescale 1ns/1ps
module tacl_config_sva
	import tacl_pkg::*;
(
	input wire logic          ref_clk,        // device clock
	input wire logic          reset_n,        // sync reset, low
	input wire logic [7:0]    reg_addr,       // register pointer
	input wire logic          reg_wr,         // write strobe
	input wire logic [15:0]   reg_wdata,      // write data
	input wire logic          reg_rd,         // read strobe
	input wire logic [15:0]   reg_rdata,      // read data
	input wire logic          upper_limit_we, // upper limit write
	input wire logic          lower_limit_we, // lower limit write
	input wire logic          crit_limit_we,  // critical limit write
	input wire logic          sensor_off,     // power down
	input wire tacl_trip_type trip_status     // trip bits
);
	logic crit_lk_q;
	logic win_lk_q;
	logic cfg_wr;
	logic any_lk;
	assign cfg_wr = reg_wr && reg_addr == TACL_CFG_ADDR;
	assign any_lk = crit_lk_q || win_lk_q;
	// lock shadows, cleared by reset only
	always_ff @(posedge ref_clk) begin
		crit_lk_q <= reset_n && (crit_lk_q || (cfg_wr && reg_wdata[TACL_CLOCK_BIT]));
		win_lk_q  <= reset_n && (win_lk_q || (cfg_wr && reg_wdata[TACL_WLOCK_BIT]));
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_cfg_rd; reg_rd && reg_addr == TACL_CFG_ADDR; endsequence
	property p_clr_rd; s_cfg_rd |=> reg_rdata[TACL_CLR_BIT] == 1'b0; endproperty
	a_clr_rd: assert property (p_clr_rd) else $error("clear bit reads one");
	property p_lock_rd; s_cfg_rd |=> reg_rdata[7:6] == $past({crit_lk_q, win_lk_q}); endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("lock readback wrong");
	property p_crit_we; crit_limit_we == (reg_wr && reg_addr == TACL_CRIT_ADDR && !crit_lk_q); endproperty
	a_crit_we: assert property (p_crit_we) else $error("critical limit write gate");
	property p_win_we;
		upper_limit_we == (reg_wr && reg_addr == TACL_UPPER_ADDR && !win_lk_q) &&
		lower_limit_we == (reg_wr && reg_addr == TACL_LOWER_ADDR && !win_lk_q);
	endproperty
	a_win_we: assert property (p_win_we) else $error("window limit write gate");
	property p_shdn_keep; cfg_wr && any_lk && !sensor_off |=> !sensor_off; endproperty
	a_shdn_keep: assert property (p_shdn_keep) else $error("shutdown set under lock");
	property p_shdn_clr; cfg_wr && !reg_wdata[TACL_SHDN_BIT] |=> !sensor_off; endproperty
	a_shdn_clr: assert property (p_shdn_clr) else $error("shutdown not cleared");
	property p_shdn_set; cfg_wr && !any_lk |=> sensor_off == $past(reg_wdata[TACL_SHDN_BIT]); endproperty
	a_shdn_set: assert property (p_shdn_set) else $error("shutdown write lost");
	property p_frozen; sensor_off && $past(sensor_off) |=> $stable(trip_status); endproperty
	a_frozen: assert property (p_frozen) else $error("trip moved in shutdown");
endmodule
bind tacl_config tacl_config_sva i_sva (.ref_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rd, .reg_rdata, .upper_limit_we, .lower_limit_we, .crit_limit_we, .sensor_off,
	.trip_status);

// ===== tb/tacl_host.sv
// host model issuing register strobes
`timescale 1ns/1ps
module tacl_host (
	input  wire logic        ref_clk,   // device clock
	input  wire logic [15:0] reg_rdata, // read data
	output logic      [7:0]  reg_addr,  // register pointer
	output logic             reg_wr,    // write strobe
	output logic      [15:0] reg_wdata, // write data
	output logic             reg_rd     // read strobe
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the configuration and alert control
`timescale 1ns/1ps
module tb_top
	import tacl_pkg::*;
;
	logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr, reg_rd, temp_valid = 1'b0;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [12:0] temp_value = 13'h0050;
	logic up_we, lo_we, cr_we, sensor_off, alert_pin_o, alert_pin_oe;
	tacl_trip_type trip_status;
	int n_errors = 0, n_checks = 0;
	always #12.5 ref_clk = ~ref_clk;
	tacl_config i_dut (.ref_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.temp_valid, .temp_value, .upper_limit(13'h0100), .lower_limit(13'h0000),
		.crit_limit(13'h0200), .upper_limit_we(up_we), .lower_limit_we(lo_we),
		.crit_limit_we(cr_we), .sensor_off, .trip_status, .alert_pin_o, .alert_pin_oe);
	tacl_host i_host (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
	// ----------------------------------------
	// shared checks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [15:0] exp);
		i_host.rd(TACL_CFG_ADDR, v);
		chk(v, exp);
	endtask
	task automatic temp(input logic [12:0] t, input logic [2:0] trip, input logic oe);
		@(posedge ref_clk);
		#1 temp_value = t;
		temp_valid = 1'b1;
		@(posedge ref_clk);
		#1 temp_valid = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 chk({13'h0000, trip_status}, {13'h0000, trip});
		chk({15'h0000, alert_pin_oe}, {15'h0000, oe});
		chk({15'h0000, alert_pin_o}, 16'h0000);
	endtask
	// limit write gates are combinational, so look while the strobe stands
	task automatic lim_chk(input logic [7:0] a, input logic [2:0] exp);
		fork
			i_host.wr(a, 16'h0000);
			begin
				@(posedge ref_clk);
				#2 chk({13'h0000, cr_we, up_we, lo_we}, {13'h0000, exp});
			end
		join
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_fields();
		rd_chk(16'h0000);
		lim_chk(TACL_CRIT_ADDR, 3'b100);
		lim_chk(TACL_UPPER_ADDR, 3'b010);
		lim_chk(TACL_LOWER_ADDR, 3'b001);
		i_host.rd(TACL_UPPER_ADDR, v);
		chk(v, 16'h0000);
		i_host.wr(TACL_CFG_ADDR, 16'h063F);
		rd_chk(16'h060F);
		i_host.wr(TACL_CFG_ADDR, 16'h0000);
	endtask
	task automatic t_compare();
		i_host.wr(TACL_CFG_ADDR, 16'h0008);
		temp(13'h0150, 3'b010, 1'b1);
		rd_chk(16'h0018);
		temp(13'h0250, 3'b110, 1'b1);
		temp(13'h1FF0, 3'b001, 1'b1);
		temp(13'h0050, 3'b000, 1'b0);
	endtask
	task automatic t_hyst();
		i_host.wr(TACL_CFG_ADDR, 16'h0408);
		temp(13'h0150, 3'b010, 1'b1);
		temp(13'h00E0, 3'b010, 1'b1);
		temp(13'h00D0, 3'b000, 1'b0);
	endtask
	task automatic t_select();
		i_host.wr(TACL_CFG_ADDR, 16'h000C);
		temp(13'h0150, 3'b010, 1'b0);
		i_host.wr(TACL_CFG_ADDR, 16'h000A);
		temp(13'h0050, 3'b000, 1'b1);
	endtask
	task automatic t_int();
		i_host.wr(TACL_CFG_ADDR, 16'h0009);
		temp(13'h0150, 3'b010, 1'b1);
		temp(13'h0050, 3'b000, 1'b1);
		i_host.wr(TACL_CFG_ADDR, 16'h0029);
		@(posedge ref_clk);
		#1 chk({15'h0000, alert_pin_oe}, 16'h0000);
		i_host.wr(TACL_CFG_ADDR, 16'h0000);
	endtask
	task automatic t_shut();
		i_host.wr(TACL_CFG_ADDR, 16'h0100);
		chk({15'h0000, sensor_off}, 16'h0001);
		temp(13'h0150, 3'b000, 1'b0);
		i_host.wr(TACL_CFG_ADDR, 16'h0000);
		temp(13'h0050, 3'b000, 1'b0);
	endtask
	task automatic t_lock();
		i_host.wr(TACL_CFG_ADDR, 16'h0100);
		i_host.wr(TACL_CFG_ADDR, 16'h0188);
		// host clears shutdown; locked fields stay
		i_host.wr(TACL_CFG_ADDR, 16'h0000);
		chk({15'h0000, sensor_off}, 16'h0000);
		rd_chk(16'h0088);
		i_host.wr(TACL_CFG_ADDR, 16'h0507);
		rd_chk(16'h0088);
		lim_chk(TACL_CRIT_ADDR, 3'b000);
		lim_chk(TACL_UPPER_ADDR, 3'b010);
		i_host.wr(TACL_CFG_ADDR, 16'h0040);
		rd_chk(16'h00C8);
		lim_chk(TACL_LOWER_ADDR, 3'b000);
		lim_chk(TACL_UPPER_ADDR, 3'b000);
		@(posedge ref_clk);
		#1 reset_n = 1'b0;
		@(posedge ref_clk);
		#1 reset_n = 1'b1;
		rd_chk(16'h0000);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		t_fields();
		t_compare();
		t_hyst();
		t_select();
		t_int();
		t_shut();
		t_lock();
		report_and_stop();
	end
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
endmodule
